// ===== rtl/ctdc_regs.sv
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module ctdc_regs #(
	parameter int unsigned SW = ctdc_pkg::SAMPLE_WIDTH,
	parameter int unsigned MOD_DIV = ctdc_pkg::MOD_CLK_DIV
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Avalon-MM slave
	input wire logic [9:0] avs_address,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Audio inputs
	input wire logic sample_valid,
	input wire logic signed [SW-1:0] ch1_in,
	input wire logic signed [SW-1:0] ch2_in,
	input wire logic signed [SW-1:0] ch4_in,
	input wire logic pdm3_in,
	input wire logic pdm4_in,
	// Audio outputs
	output logic pdm3_out,
	output logic pdm4_out,
	output logic signed [SW-1:0] ch4_out,
	output logic ch4_out_valid,
	output logic signed [SW-1:0] sum_out,
	output logic sum_out_valid,
	// Filter configuration
	output logic [1:0] decimation_response_sel,
	output logic [1:0] summation_sel,
	output logic [1:0] highpass_sel
);
	// ----------------------------------------------------------------
	// Gain tables
	// ----------------------------------------------------------------
	// Half-dB steps inside one 6 dB octave, unity is 16'h4000.
	function automatic logic [15:0] coarse_gain(input logic [3:0] n);
		logic [15:0] v;
		case (n)
			4'h0: v = 16'h4000;
			4'h1: v = 16'h43cc;
			4'h2: v = 16'h47cf;
			4'h3: v = 16'h4c10;
			4'h4: v = 16'h5092;
			4'h5: v = 16'h5558;
			4'h6: v = 16'h5a66;
			4'h7: v = 16'h5fc2;
			4'h8: v = 16'h656f;
			4'h9: v = 16'h6b71;
			4'ha: v = 16'h71cf;
			default: v = 16'h788e;
		endcase
		return v;
	endfunction : coarse_gain

	function automatic logic [15:0] fine_gain(input logic [2:0] m);
		logic [15:0] v;
		case (m)
			3'h0: v = 16'h4000;
			3'h1: v = 16'h40be;
			3'h2: v = 16'h417e;
			3'h3: v = 16'h4240;
			default: v = 16'h4305;
		endcase
		return v;
	endfunction : fine_gain

	// ----------------------------------------------------------------
	// Modulator tick divider
	// ----------------------------------------------------------------
	localparam int unsigned DW = (MOD_DIV > 1) ? $clog2(MOD_DIV) : 1;
	localparam logic [DW-1:0] DIV_LAST = DW'(MOD_DIV - 1);

	logic [DW-1:0] div_q;
	logic [DW-1:0] div_d;
	logic tick_q;
	logic tick_d;

	always_comb begin
		div_d = div_q + 1'b1;
		tick_d = 1'b0;
		if (div_q == DIV_LAST) begin
			div_d = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	typedef enum logic {BUS_IDLE, BUS_ACK} ctdc_bus_type;

	ctdc_bus_type bus_q;
	ctdc_bus_type bus_d;
	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [7:0] idx;
	logic [7:0] rd_byte;
	logic wr_commit;

	logic [7:0] ch3_phase_q;
	logic [7:0] ch3_phase_d;
	logic [7:0] ch4_vol_q;
	logic [7:0] ch4_vol_d;
	logic [7:0] ch4_gain_q;
	logic [7:0] ch4_gain_d;
	logic [7:0] ch4_phase_q;
	logic [7:0] ch4_phase_d;
	logic [7:0] proc_cfg_q;
	logic [7:0] proc_cfg_d;

	assign idx = avs_address[9:2];

	always_comb begin
		if (idx == ctdc_pkg::IDX_CH3_PHASE_TRIM) begin
			rd_byte = ch3_phase_q;
		end else if (idx == ctdc_pkg::IDX_CH4_VOLUME) begin
			rd_byte = ch4_vol_q;
		end else if (idx == ctdc_pkg::IDX_CH4_GAIN_TRIM) begin
			rd_byte = ch4_gain_q;
		end else if (idx == ctdc_pkg::IDX_CH4_PHASE_TRIM) begin
			rd_byte = ch4_phase_q;
		end else if (idx == ctdc_pkg::IDX_PROCESSING_CONFIG0) begin
			rd_byte = proc_cfg_q;
		end else begin
			rd_byte = 8'h00;
		end
	end

	// The answer is registered, so every access costs exactly two cycles;
	// that keeps the decode off the bus timing path at a small price in rate.
	always_comb begin
		bus_d = bus_q;
		wait_d = 1'b1;
		rdata_d = rdata_q;
		case (bus_q)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					bus_d = BUS_ACK;
					wait_d = 1'b0;
					rdata_d = {24'h000000, rd_byte};
				end
			end
			BUS_ACK: begin
				bus_d = BUS_IDLE;
			end
			default: begin
				bus_d = BUS_IDLE;
			end
		endcase
	end

	assign wr_commit = (bus_q == BUS_ACK) && avs_write && avs_byteenable[0];

	always_comb begin
		ch3_phase_d = ch3_phase_q;
		ch4_vol_d = ch4_vol_q;
		ch4_gain_d = ch4_gain_q;
		ch4_phase_d = ch4_phase_q;
		proc_cfg_d = proc_cfg_q;
		if (wr_commit) begin
			if (idx == ctdc_pkg::IDX_CH3_PHASE_TRIM) begin
				ch3_phase_d = avs_writedata[7:0];
			end else if (idx == ctdc_pkg::IDX_CH4_VOLUME) begin
				ch4_vol_d = avs_writedata[7:0];
			end else if (idx == ctdc_pkg::IDX_CH4_GAIN_TRIM) begin
				ch4_gain_d = avs_writedata[7:0] & ctdc_pkg::GAIN_TRIM_WR_MASK;
			end else if (idx == ctdc_pkg::IDX_CH4_PHASE_TRIM) begin
				ch4_phase_d = avs_writedata[7:0];
			end else if (idx == ctdc_pkg::IDX_PROCESSING_CONFIG0) begin
				proc_cfg_d = avs_writedata[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_q <= BUS_IDLE;
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
			ch3_phase_q <= ctdc_pkg::RST_CH3_PHASE_TRIM;
			ch4_vol_q <= ctdc_pkg::RST_CH4_VOLUME;
			ch4_gain_q <= ctdc_pkg::RST_CH4_GAIN_TRIM;
			ch4_phase_q <= ctdc_pkg::RST_CH4_PHASE_TRIM;
			proc_cfg_q <= ctdc_pkg::RST_PROCESSING_CONFIG0;
		end else begin
			bus_q <= bus_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			ch3_phase_q <= ch3_phase_d;
			ch4_vol_q <= ch4_vol_d;
			ch4_gain_q <= ch4_gain_d;
			ch4_phase_q <= ch4_phase_d;
			proc_cfg_q <= proc_cfg_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;

	assign decimation_response_sel = proc_cfg_q[ctdc_pkg::DECIMATION_LSB +: 2];
	assign summation_sel = proc_cfg_q[ctdc_pkg::SUMMATION_LSB +: 2];
	assign highpass_sel = proc_cfg_q[ctdc_pkg::HIGHPASS_LSB +: 2];

	// ----------------------------------------------------------------
	// Settings applied at the sample boundary
	// ----------------------------------------------------------------
	logic [7:0] act_ch3_phase_q;
	logic [7:0] act_ch3_phase_d;
	logic [7:0] act_ch4_phase_q;
	logic [7:0] act_ch4_phase_d;
	logic [7:0] act_vol_q;
	logic [7:0] act_vol_d;
	logic [3:0] act_trim_q;
	logic [3:0] act_trim_d;
	logic signed [SW-1:0] sum_q;
	logic signed [SW-1:0] sum_d;
	logic sum_valid_q;
	logic signed [SW:0] sum_wide;

	always_comb begin
		act_ch3_phase_d = act_ch3_phase_q;
		act_ch4_phase_d = act_ch4_phase_q;
		act_vol_d = act_vol_q;
		act_trim_d = act_trim_q;
		sum_wide = ((SW+1)'(ch1_in) + (SW+1)'(ch2_in)) >>> 1;
		sum_d = sum_q;
		if (sample_valid) begin
			act_ch3_phase_d = ch3_phase_q;
			act_ch4_phase_d = ch4_phase_q;
			act_vol_d = ch4_vol_q;
			act_trim_d = ch4_gain_q[ctdc_pkg::GAIN_TRIM_LSB +: 4];
			if (summation_sel == ctdc_pkg::SUM_AVG_CH12) begin
				sum_d = sum_wide[SW-1:0];
			end else begin
				sum_d = ch1_in;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			act_ch3_phase_q <= ctdc_pkg::RST_CH3_PHASE_TRIM;
			act_ch4_phase_q <= ctdc_pkg::RST_CH4_PHASE_TRIM;
			act_vol_q <= ctdc_pkg::RST_CH4_VOLUME;
			act_trim_q <= ctdc_pkg::RST_CH4_GAIN_TRIM[ctdc_pkg::GAIN_TRIM_LSB +: 4];
			sum_q <= '0;
			sum_valid_q <= 1'b0;
		end else begin
			act_ch3_phase_q <= act_ch3_phase_d;
			act_ch4_phase_q <= act_ch4_phase_d;
			act_vol_q <= act_vol_d;
			act_trim_q <= act_trim_d;
			sum_q <= sum_d;
			sum_valid_q <= sample_valid;
		end
	end

	assign sum_out = sum_q;
	assign sum_out_valid = sum_valid_q;

	// ----------------------------------------------------------------
	// Phase trim delay lines
	// ----------------------------------------------------------------
	ctdc_delay_line #(
		.DEPTH(ctdc_pkg::PHASE_DEPTH),
		.AW(8)
	) u_ch3_delay (
		.clk(clk),
		.rstn(rstn),
		.tick(tick_q),
		.din(pdm3_in),
		.delay(act_ch3_phase_q),
		.dout(pdm3_out)
	);

	ctdc_delay_line #(
		.DEPTH(ctdc_pkg::PHASE_DEPTH),
		.AW(8)
	) u_ch4_delay (
		.clk(clk),
		.rstn(rstn),
		.tick(tick_q),
		.din(pdm4_in),
		.delay(act_ch4_phase_q),
		.dout(pdm4_out)
	);

	// ----------------------------------------------------------------
	// Channel 4 volume and gain trim
	// ----------------------------------------------------------------
	// Octaves are taken as 6.0 dB, so large cuts drift from the true
	// law by up to 0.3 percent per octave; a full table would cost far more.
	logic signed [12:0] tenths;
	logic [11:0] ofs;
	logic [11:0] octave;
	logic [11:0] rem;
	logic [11:0] step;
	logic [11:0] frac;

	ctdc_gain_if #(.SW(SW)) gif ();

	always_comb begin
		tenths = ($signed({5'h00, act_vol_q}) - ctdc_pkg::VOLUME_UNITY_CODE)
			* ctdc_pkg::TENTHS_PER_HALF_DB
			+ $signed({9'h000, act_trim_q}) - ctdc_pkg::GAIN_TRIM_UNITY_CODE;
		ofs = 12'(tenths + ctdc_pkg::TENTHS_OFFSET);
		octave = ofs / ctdc_pkg::TENTHS_PER_OCTAVE;
		rem = 12'(ofs - 12'(octave * ctdc_pkg::TENTHS_PER_OCTAVE));
		step = rem / ctdc_pkg::TENTHS_PER_STEP;
		frac = 12'(rem - 12'(step * ctdc_pkg::TENTHS_PER_STEP));
	end

	assign gif.valid = sample_valid;
	assign gif.mute = (act_vol_q == ctdc_pkg::VOLUME_MUTE_CODE);
	assign gif.coarse = coarse_gain(step[3:0]);
	assign gif.fine = fine_gain(frac[2:0]);
	assign gif.shift = $signed(octave[5:0]) - ctdc_pkg::OCTAVE_UNITY;
	assign gif.din = ch4_in;

	ctdc_gain_stage #(
		.SW(SW)
	) u_gain (
		.clk(clk),
		.rstn(rstn),
		.g(gif.stage)
	);

	assign ch4_out = gif.dout;
	assign ch4_out_valid = gif.dout_valid;
endmodule : ctdc_regs

`default_nettype wire

// ===== rtl/ctdc_pkg.sv
package ctdc_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CH3_PHASE_TRIM = 8'h4a;
	localparam logic [7:0] IDX_CH4_VOLUME = 8'h4d;
	localparam logic [7:0] IDX_CH4_GAIN_TRIM = 8'h4e;
	localparam logic [7:0] IDX_CH4_PHASE_TRIM = 8'h4f;
	localparam logic [7:0] IDX_PROCESSING_CONFIG0 = 8'h6b;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CH3_PHASE_TRIM = 8'h00;
	localparam logic [7:0] RST_CH4_VOLUME = 8'hc9;
	localparam logic [7:0] RST_CH4_GAIN_TRIM = 8'h80;
	localparam logic [7:0] RST_CH4_PHASE_TRIM = 8'h00;
	localparam logic [7:0] RST_PROCESSING_CONFIG0 = 8'h01;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] GAIN_TRIM_WR_MASK = 8'hf0;
	localparam int unsigned GAIN_TRIM_LSB = 4;
	localparam int unsigned DECIMATION_LSB = 4;
	localparam int unsigned SUMMATION_LSB = 2;
	localparam int unsigned HIGHPASS_LSB = 0;

	// ----------------------------------------------------------------
	// Gain law
	// ----------------------------------------------------------------
	localparam logic [7:0] VOLUME_MUTE_CODE = 8'h00;
	localparam logic signed [12:0] VOLUME_UNITY_CODE = 13'sh0c9;
	localparam logic signed [12:0] GAIN_TRIM_UNITY_CODE = 13'sh008;
	localparam logic signed [12:0] TENTHS_PER_HALF_DB = 13'sh005;
	localparam logic signed [12:0] TENTHS_OFFSET = 13'sh4b0;
	localparam logic [11:0] TENTHS_PER_OCTAVE = 12'h03c;
	localparam logic [11:0] TENTHS_PER_STEP = 12'h005;
	localparam logic signed [5:0] OCTAVE_UNITY = 6'sh14;
	localparam int unsigned GAIN_FRAC_BITS = 14;

	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------
	localparam int unsigned SAMPLE_WIDTH = 24;
	localparam int unsigned PHASE_DEPTH = 256;
	localparam int unsigned MOD_CLK_DIV = 8;

	// ----------------------------------------------------------------
	// Mode encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {DECI_LINEAR, DECI_LOW_LATENCY, DECI_ULTRA_LOW, DECI_RESERVED}
		ctdc_deci_type;
	typedef enum logic [1:0] {SUM_OFF, SUM_AVG_CH12, SUM_RESERVED2, SUM_RESERVED3} ctdc_sum_type;
	typedef enum logic [1:0] {HPF_PROGRAMMABLE, HPF_FC_00025, HPF_FC_0002, HPF_FC_0008}
		ctdc_hpf_type;

endpackage : ctdc_pkg

// ===== rtl/ctdc_gain_if.sv
`timescale 1ns/10ps
`default_nettype none

interface ctdc_gain_if #(
	parameter int unsigned SW = 24
);
	logic valid;
	logic mute;
	logic [15:0] coarse;
	logic [15:0] fine;
	logic signed [5:0] shift;
	logic signed [SW-1:0] din;
	logic signed [SW-1:0] dout;
	logic dout_valid;

	modport ctrl (output valid, output mute, output coarse, output fine, output shift,
		output din, input dout, input dout_valid);
	modport stage (input valid, input mute, input coarse, input fine, input shift,
		input din, output dout, output dout_valid);
endinterface : ctdc_gain_if

`default_nettype wire

// ===== rtl/ctdc_delay_line.sv
`timescale 1ns/10ps
`default_nettype none

module ctdc_delay_line #(
	parameter int unsigned DEPTH = 256,
	parameter int unsigned AW = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Stream
	input wire logic tick,
	input wire logic din,
	input wire logic [AW-1:0] delay,
	output logic dout
);
	logic mem [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] wptr_d;
	logic dout_q;
	logic dout_d;

	always_comb begin
		wptr_d = wptr_q;
		dout_d = dout_q;
		if (tick) begin
			wptr_d = wptr_q + 1'b1;
			if (delay == '0) begin
				dout_d = din;
			end else begin
				dout_d = mem[wptr_q - delay];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (tick) begin
			mem[wptr_q] <= din;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wptr_q <= '0;
			dout_q <= 1'b0;
		end else begin
			wptr_q <= wptr_d;
			dout_q <= dout_d;
		end
	end

	assign dout = dout_q;
endmodule : ctdc_delay_line

`default_nettype wire

// ===== rtl/ctdc_gain_stage.sv
`timescale 1ns/10ps
`default_nettype none

module ctdc_gain_stage #(
	parameter int unsigned SW = 24
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Gain control and samples
	ctdc_gain_if.stage g
);
	localparam int unsigned PW = 48;
	localparam logic signed [PW-1:0] MAX_S = PW'({1'b0, {(SW-1){1'b1}}});
	localparam logic signed [PW-1:0] MIN_S = -MAX_S - 1;

	logic signed [PW-1:0] p1;
	logic signed [PW-1:0] p2;
	logic signed [PW-1:0] p3;
	logic signed [SW-1:0] dout_q;
	logic signed [SW-1:0] dout_d;
	logic valid_q;
	logic valid_d;

	always_comb begin
		p1 = (PW'(g.din) * $signed(PW'(g.coarse))) >>> ctdc_pkg::GAIN_FRAC_BITS;
		p2 = (p1 * $signed(PW'(g.fine))) >>> ctdc_pkg::GAIN_FRAC_BITS;
		if (g.shift >= 0) begin
			p3 = p2 <<< g.shift;
		end else begin
			p3 = p2 >>> (-g.shift);
		end
		valid_d = g.valid;
		dout_d = dout_q;
		if (g.valid) begin
			if (g.mute) begin
				dout_d = '0;
			end else if (p3 > MAX_S) begin
				dout_d = MAX_S[SW-1:0];
			end else if (p3 < MIN_S) begin
				dout_d = MIN_S[SW-1:0];
			end else begin
				dout_d = p3[SW-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dout_q <= '0;
			valid_q <= 1'b0;
		end else begin
			dout_q <= dout_d;
			valid_q <= valid_d;
		end
	end

	assign g.dout = dout_q;
	assign g.dout_valid = valid_q;
endmodule : ctdc_gain_stage

`default_nettype wire

// ===== verification/ctdc_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module ctdc_regs_chk #(
	parameter int unsigned SW = 24,
	parameter int unsigned MOD_DIV = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register bus
	input wire logic [9:0] avs_address,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Audio
	input wire logic sample_valid,
	input wire logic signed [SW-1:0] ch1_in,
	input wire logic signed [SW-1:0] ch2_in,
	input wire logic signed [SW-1:0] ch4_in,
	input wire logic pdm3_in,
	input wire logic pdm4_in,
	input wire logic pdm3_out,
	input wire logic pdm4_out,
	input wire logic signed [SW-1:0] ch4_out,
	input wire logic ch4_out_valid,
	input wire logic signed [SW-1:0] sum_out,
	input wire logic sum_out_valid,
	// Filter configuration
	input wire logic [1:0] decimation_response_sel,
	input wire logic [1:0] summation_sel,
	input wire logic [1:0] highpass_sel
);
	// ----------------------------------------------------------------
	// Shadow of the processing configuration
	// ----------------------------------------------------------------
	logic wr_cfg;
	logic rd_done;
	logic [7:0] cfg_d;
	logic [7:0] cfg_q;
	logic signed [SW:0] pair_sum;
	assign wr_cfg = avs_write && !avs_waitrequest && avs_byteenable[0]
		&& avs_address[9:2] == 8'h6b;
	assign rd_done = avs_read && !avs_waitrequest;
	assign pair_sum = ch1_in + ch2_in;
	always_comb begin
		cfg_d = wr_cfg ? avs_writedata[7:0] : cfg_q;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) cfg_q <= 8'h01;
		else cfg_q <= cfg_d;
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait cycle");
	read_upper_a: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	nibble_zero_a: assert property (rd_done && avs_address[9:2] == 8'h4e |-> avs_readdata[3:0] == 4'h0)
		else $error("gain trim low nibble reads nonzero");
	deci_follow_a: assert property (wr_cfg |=> ##[0:1] decimation_response_sel == cfg_q[5:4])
		else $error("decimation select does not follow write");
	cfg_fields_a: assert property (!wr_cfg && !$past(wr_cfg)
		|-> {decimation_response_sel, summation_sel, highpass_sel} == cfg_q[5:0])
		else $error("selects differ from configuration");
	sum_avg_a: assert property (sample_valid && summation_sel == 2'h1 && $stable(summation_sel)
		|=> sum_out == $past(pair_sum[SW:1]))
		else $error("sum output is not the average");
	sum_off_a: assert property (sample_valid && summation_sel == 2'h0 && $stable(summation_sel)
		|=> sum_out == $past(ch1_in))
		else $error("sum output not channel 1 with summing off");
	valid_pulse_a: assert property (sample_valid |=> ch4_out_valid && sum_out_valid)
		else $error("output valid missing after sample");
	valid_quiet_a: assert property (!sample_valid |=> !ch4_out_valid && !sum_out_valid)
		else $error("output valid without sample");
	pdm_tick_a: assert property ($changed(pdm3_out) || $changed(pdm4_out)
		|=> $stable(pdm3_out) && $stable(pdm4_out))
		else $error("delayed stream changed off tick");
endmodule : ctdc_regs_chk

bind ctdc_regs ctdc_regs_chk #(.SW(SW), .MOD_DIV(MOD_DIV)) chk_i (.clk(clk), .rstn(rstn),
	.avs_address(avs_address), .avs_byteenable(avs_byteenable), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid), .ch1_in(ch1_in),
	.ch2_in(ch2_in), .ch4_in(ch4_in), .pdm3_in(pdm3_in), .pdm4_in(pdm4_in),
	.pdm3_out(pdm3_out), .pdm4_out(pdm4_out), .ch4_out(ch4_out), .ch4_out_valid(ch4_out_valid),
	.sum_out(sum_out), .sum_out_valid(sum_out_valid),
	.decimation_response_sel(decimation_response_sel), .summation_sel(summation_sel),
	.highpass_sel(highpass_sel));

`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
	typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} ctdc_row_type;
	localparam int MD = 4;
	logic clk, rstn, rd_e, wr_e, sv, p3, p4, p3o, p4o, c4v, sumv, waitreq;
	logic [9:0] addr;
	logic [3:0] be;
	logic [31:0] wdat, rdat, q;
	logic signed [23:0] c1, c2, c4, c4o, sumo;
	logic [1:0] dsel, ssel, hsel;
	int mismatches, n_checks, l0, ld;
	ctdc_row_type rows [7] = '{'{8'h4a, 8'hff, 8'hff}, '{8'h4f, 8'ha5, 8'ha5},
		'{8'h4e, 8'hff, 8'hf0}, '{8'h4e, 8'h35, 8'h30}, '{8'h6b, 8'hff, 8'hff},
		'{8'h6b, 8'h26, 8'h26}, '{8'h4d, 8'h00, 8'h00}};

	ctdc_regs #(.SW(24), .MOD_DIV(MD)) uut (.clk(clk), .rstn(rstn), .avs_address(addr),
		.avs_byteenable(be), .avs_read(rd_e), .avs_write(wr_e), .avs_writedata(wdat),
		.avs_readdata(rdat), .avs_waitrequest(waitreq), .sample_valid(sv), .ch1_in(c1),
		.ch2_in(c2), .ch4_in(c4), .pdm3_in(p3), .pdm4_in(p4), .pdm3_out(p3o), .pdm4_out(p4o),
		.ch4_out(c4o), .ch4_out_valid(c4v), .sum_out(sumo), .sum_out_valid(sumv),
		.decimation_response_sel(dsel), .summation_sel(ssel), .highpass_sel(hsel));

	// ----------------------------------------------------------------
	// Compare and bus tasks
	// ----------------------------------------------------------------
	task automatic bad(string msg);
		mismatches++;
		$display("BAD %0t %s", $time, msg);
	endtask : bad
	task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
		n_checks++;
		if (got !== exp) bad(msg);
	endtask : chk
	task automatic near(logic signed [23:0] got, int lo, int hi);
		n_checks++;
		if (^got === 1'bx || got < lo || got > hi) bad("gain out of range");
	endtask : near
	task automatic bus(logic w, logic [7:0] idx, logic [7:0] d, logic b0);
		int n;
		@(posedge clk);
		wr_e <= w;
		rd_e <= !w;
		addr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		be <= {3'b111, b0};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		q = rdat;
		if (n >= 20) bad("no bus answer");
		wr_e <= 1'b0;
		rd_e <= 1'b0;
	endtask : bus
	task automatic wr(logic [7:0] idx, logic [7:0] d);
		bus(1'b1, idx, d, 1'b1);
		// The register takes the write at the answer edge, so let it settle first.
		@(posedge clk);
	endtask : wr
	task automatic rd(logic [7:0] idx, logic [7:0] e);
		bus(1'b0, idx, 8'h00, 1'b1);
		chk(q, {24'h0, e}, "read value");
	endtask : rd
	task automatic smp(logic signed [23:0] a, logic signed [23:0] b, logic signed [23:0] c);
		@(posedge clk);
		sv <= 1'b1;
		c1 <= a;
		c2 <= b;
		c4 <= c;
		@(posedge clk);
		sv <= 1'b0;
		#1;
	endtask : smp
	task automatic gcase(logic [7:0] v, logic [7:0] t, int x, int lo, int hi);
		wr(8'h4d, v);
		wr(8'h4e, t);
		// The first sample only moves the new settings into the active set.
		smp(24'sd1000, 24'sd1000, x);
		smp(24'sd1000, 24'sd1000, x);
		near(c4o, lo, hi);
	endtask : gcase
	// Latency is counted from a flip that sits a whole number of ticks after the
	// output last followed, so tick phase cancels when two latencies are subtracted.
	// The line is flushed first, so that stale history cannot look like the echo.
	task automatic pmeas(logic [7:0] idx, logic [7:0] d, output int lat);
		logic t;
		wr(idx, d);
		smp(24'sd0, 24'sd0, 24'sd0);
		repeat (260 * MD) @(posedge clk);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			t = ~p3;
			p3 <= t;
			p4 <= t;
			lat = 0;
			do begin
				@(posedge clk);
				lat++;
			end while ((idx == 8'h4a ? p3o : p4o) !== t && lat < 2000);
			if (k == 0) repeat (320 * MD - 1) @(posedge clk);
		end
	endtask : pmeas
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		bad("watchdog expired");
		wrap_up();
	end
	initial begin
		{rstn, rd_e, wr_e, sv, p3, p4, addr, be, wdat, c1, c2, c4} = '0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(8'h4a, 8'h00);
		rd(8'h4d, 8'hc9);
		rd(8'h4e, 8'h80);
		rd(8'h4f, 8'h00);
		rd(8'h6b, 8'h01);
		wr(8'h00, 8'h55);
		rd(8'h00, 8'h00);
		bus(1'b1, 8'h4d, 8'h11, 1'b0);
		rd(8'h4d, 8'hc9);
		smp(24'sd100000, 24'sd0, 24'sd300000);
		chk(c4o, 24'sd300000, "unity gain");
		chk(sumo, 24'sd100000, "sum off");
		chk({c4v, sumv}, 2'b11, "valid pulse");
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd);
			rd(rows[i].idx, rows[i].rd);
		end
		chk({dsel, ssel, hsel}, 6'h26, "selects");
		smp(24'sd1000, 24'sd1000, 24'sd300000);
		chk(c4o, 24'sd300000, "settings applied early");
		smp(-24'sd5, 24'sd2, 24'sd300000);
		chk(c4o, 24'sd0, "mute");
		chk(sumo, -24'sd2, "average");
		for (int k = 0; k < 4; k++) begin
			wr(8'h6b, {2'b00, k[1:0], k[1:0], k[1:0]});
			chk({dsel, ssel, hsel}, {3{k[1:0]}}, "mode codes");
		end
		gcase(8'd213, 8'h80, 100000, 196000, 204000);
		gcase(8'd189, 8'h80, 100000, 49000, 51000);
		gcase(8'd255, 8'h80, 1000, 21900, 23000);
		gcase(8'd1, 8'h80, 8000000, 60, 100);
		gcase(8'd201, 8'h00, 100000, 90000, 92400);
		gcase(8'd201, 8'hf0, 100000, 107000, 109800);
		pmeas(8'h4a, 8'd0, l0);
		chk(l0 <= 2 * MD + 2, 1, "zero trim adds delay");
		pmeas(8'h4a, 8'd5, ld);
		chk(ld - l0, 5 * MD, "phase trim 5");
		pmeas(8'h4a, 8'd255, ld);
		chk(ld - l0, 255 * MD, "phase trim 255");
		pmeas(8'h4f, 8'd2, ld);
		chk(ld - l0, 2 * MD, "channel 4 trim");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(8'h4f, 8'h00);
		rd(8'h6b, 8'h01);
		chk({dsel, ssel, hsel}, 6'h01, "selects after reset");
		wrap_up();
	end
endmodule : tb

`default_nettype wire
